/* rtl/vds_defines.svh */
// vds_defines.svh: offsets, field positions and timing counts of the slicer
// readout. Definitions only; included by the slicer design file.
`ifndef VDS_DEFINES_SVH
`define VDS_DEFINES_SVH

// link frame: field, line number, byte a, byte b, msb first
`define VDS_FRAME_BITS 5'h1b
`define VDS_CNT_MAX 5'h1f
`define VDS_FLD_BIT 26
`define VDS_LINE_HI 25
`define VDS_LINE_LO 16
`define VDS_LINE_W 10
`define VDS_WORD_W 17

// second-field carrier line sits this far above the first-field line
`define VDS_F2_LINE_OFS 10'h107

// readable subaddresses and status bit positions
`define VDS_SUB_DATA_A 8'h2a
`define VDS_SUB_DATA_B 8'h2b
`define VDS_SUB_STATUS 8'h2c
`define VDS_ST_VALID_BIT 1
`define VDS_ST_FIELD_BIT 0

// extended data service byte codes (parity bit stripped)
`define VDS_CLS_W 5
`define VDS_TYP_W 3
`define VDS_XDS_CTL_MIN 7'h01
`define VDS_XDS_CTL_MAX 7'h0e
`define VDS_XDS_END 7'h0f
`define VDS_CAP_CTL_HI 3'h1
`define VDS_TYPE_RATING 7'h05
`define VDS_TYPE_PID 7'h01
`define VDS_TYPE_PNAME 7'h03

// interrupt pulse length
`define VDS_CLK_NS 4
`define VDS_IRQ_PULSE_NS 1000
`define VDS_IRQ_PULSE_CYC \
	((`VDS_IRQ_PULSE_NS + `VDS_CLK_NS - 1) / `VDS_CLK_NS)
`define VDS_PCNT_W 8

`endif

/* rtl/vds_pkg.sv */
// vds_pkg: types shared by the slicer readout.
// assumes nothing of its surroundings.
package vds_pkg;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_SHIFT = 2'b01,
		RX_HOLD = 2'b10
	} vds_rx_e;
	typedef enum logic [2:0] {
		IRQ_OFF = 3'b000,
		IRQ_PULSE = 3'b001,
		IRQ_LEVEL = 3'b010
	} vds_irq_e;
endpackage

/* rtl/vds_slicer.sv */
// vds_slicer: sliced-data readout with extended data service filter,
// word fifo, host read port and interrupt pin.
// assumes link pins are asynchronous to clk_sys; host read strobes are
// one-cycle pulses from register logic on clk_sys.
`include "vds_defines.svh"

module vds_fifo #(
	parameter int W = 17,
	parameter int D = 4
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem_r [D];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready = (cnt_r != (AW+1)'(D));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rp_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		if (push) begin
			wp_nxt = (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
		end
		if (pop) begin
			rp_nxt = (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
		end
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	for (genvar g = 0; g < D; g++) begin : g_ent
		always_ff @(posedge clk_sys) begin
			if (push && wp_r == AW'(g)) begin
				mem_r[g] <= in_data;
			end
		end
	end
endmodule

module vds_slicer #(
	parameter int FIFO_D = 4
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic lnk_clk,
	input wire logic lnk_frame,
	input wire logic lnk_dat,
	input wire logic slice_service,
	input wire logic [9:0] slice_line_select,
	input wire logic [4:0] ext_class_filter,
	input wire logic [2:0] ext_type_filter,
	input vds_pkg::vds_irq_e irq_pin_config,
	input wire logic sub_load,
	input wire logic [7:0] sub_addr,
	input wire logic rd_req,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic rd_refused,
	output logic slice_valid_flag,
	output logic slice_field_flag,
	output logic lost_frame,
	output logic irq_o,
	output logic irq_oe_n
);
	import vds_pkg::*;

	// link pins: two flops, then an edge tap off the second stage only
	logic [2:0] s1_r, s2_r;
	logic ck3_r, frm3_r;
	logic frm, dat, bit_edge, frame_rise;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
			ck3_r <= 1'b0;
			frm3_r <= 1'b0;
		end else begin
			s1_r <= {lnk_clk, lnk_frame, lnk_dat};
			s2_r <= s1_r;
			ck3_r <= s2_r[2];
			frm3_r <= s2_r[1];
		end
	end

	assign frm = s2_r[1];
	assign dat = s2_r[0];
	assign bit_edge = s2_r[2] && !ck3_r;
	assign frame_rise = frm && !frm3_r;

	// frame receiver
	vds_rx_e st_r, st_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [26:0] sh_r, sh_nxt, word_r, word_nxt;
	logic lost_r, lost_nxt;
	logic leave;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		word_nxt = word_r;
		lost_nxt = 1'b0;
		case (st_r)
			RX_IDLE: begin
				if (frm) begin
					st_nxt = RX_SHIFT;
					cnt_nxt = 5'h0;
				end
			end
			RX_SHIFT: begin
				if (frm && bit_edge && cnt_r != `VDS_CNT_MAX) begin
					sh_nxt = {sh_r[25:0], dat};
					cnt_nxt = cnt_r + 5'h1;
				end else if (!frm) begin
					// short or long frames are dropped silently
					st_nxt = (cnt_r == `VDS_FRAME_BITS) ? RX_HOLD : RX_IDLE;
					word_nxt = sh_r;
				end
			end
			RX_HOLD: begin
				// no second word buffer: a frame during a stall is lost
				lost_nxt = frame_rise;
				if (leave) begin
					st_nxt = RX_IDLE;
				end
			end
			default: st_nxt = RX_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_r <= RX_IDLE;
			cnt_r <= 5'h0;
			sh_r <= '0;
			word_r <= '0;
			lost_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			word_r <= word_nxt;
			lost_r <= lost_nxt;
		end
	end

	// filter on the held word
	logic fld, lok, xds_on, cen, tok, acc, is_ctl, is_end, is_cap;
	logic [`VDS_LINE_W-1:0] line, want;
	logic [6:0] a7, b7, cdiff;
	logic [2:0] cidx;
	logic inpkt_r, inpkt_nxt, pass_r, pass_nxt, inpkt_c, pass_c;
	logic f_iv, f_ir, f_ov, pop;
	logic [`VDS_WORD_W-1:0] f_od;

	assign fld = word_r[`VDS_FLD_BIT];
	assign line = word_r[`VDS_LINE_HI:`VDS_LINE_LO];
	assign a7 = word_r[14:8];
	assign b7 = word_r[6:0];
	assign cdiff = a7 - `VDS_XDS_CTL_MIN;
	assign cidx = cdiff[3:1];
	assign is_ctl = a7 >= `VDS_XDS_CTL_MIN && a7 <= `VDS_XDS_CTL_MAX;
	assign is_end = a7 == `VDS_XDS_END;
	assign is_cap = a7[6:4] == `VDS_CAP_CTL_HI;
	assign xds_on = !slice_service && ext_class_filter != '0;

	always_comb begin
		want = fld ? slice_line_select + `VDS_F2_LINE_OFS : slice_line_select;
		lok = line == want;
		cen = cidx < 3'(`VDS_CLS_W) && ext_class_filter[cidx];
		// type narrowing, rating tied to class bit 0
		tok = ext_type_filter == '0 ||
			(ext_type_filter[0] && ext_class_filter[0] &&
			b7 == `VDS_TYPE_RATING) ||
			(ext_type_filter[1] && b7 == `VDS_TYPE_PID) ||
			(ext_type_filter[2] && b7 == `VDS_TYPE_PNAME);
		inpkt_c = inpkt_r;
		pass_c = pass_r;
		acc = 1'b0;
		if (slice_service) begin
			// unfiltered, field from type bit 0
			acc = lok && fld == ext_type_filter[0];
		end else if (!xds_on) begin
			acc = lok;
		end else if (lok && fld) begin
			if (is_ctl) begin
				acc = cen && tok;
				inpkt_c = 1'b1;
				pass_c = cen && tok;
			end else if (is_end) begin
				acc = inpkt_r && pass_r;
				inpkt_c = 1'b0;
				pass_c = 1'b0;
			end else if (!is_cap) begin
				acc = inpkt_r && pass_r && a7 != 7'h00;
			end
		end
		leave = st_r == RX_HOLD && (!acc || f_ir);
		inpkt_nxt = leave ? inpkt_c : inpkt_r;
		pass_nxt = leave ? pass_c : pass_r;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			inpkt_r <= 1'b0;
			pass_r <= 1'b0;
		end else begin
			inpkt_r <= inpkt_nxt;
			pass_r <= pass_nxt;
		end
	end

	assign f_iv = st_r == RX_HOLD && acc;

	vds_fifo #(
		.W(`VDS_WORD_W),
		.D(FIFO_D)
	) u_fifo (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.in_valid(f_iv),
		.in_ready(f_ir),
		.in_data({fld, word_r[15:0]}),
		.out_valid(f_ov),
		.out_ready(pop),
		.out_data(f_od)
	);

	// output bytes, host read port, interrupt pin
	logic [7:0] a_r, a_nxt, b_r, b_nxt, ptr_r, ptr_nxt, rdat_r, rdat_nxt;
	logic [7:0] addr, status;
	logic fld_r, fld_nxt, valid_r, valid_nxt, ra_r, ra_nxt, rb_r, rb_nxt;
	logic rval_r, rval_nxt, rref_r, rref_nxt, irq_r, irq_nxt, oen_r, oen_nxt;
	logic hit_a, hit_b, hit_s, sfield;
	logic [`VDS_PCNT_W-1:0] pcnt_r, pcnt_nxt;

	// drain stalls while a word is held, so the fifo really fills
	assign pop = f_ov && !valid_r;
	// forced to 1 under class filtering
	assign sfield = (ext_class_filter != '0) ? 1'b1 : fld_r;

	always_comb begin
		a_nxt = a_r;
		b_nxt = b_r;
		fld_nxt = fld_r;
		valid_nxt = valid_r;
		ptr_nxt = ptr_r;
		rdat_nxt = rdat_r;
		rval_nxt = 1'b0;
		rref_nxt = 1'b0;
		status = 8'h00;
		status[`VDS_ST_VALID_BIT] = valid_r;
		status[`VDS_ST_FIELD_BIT] = sfield;
		addr = sub_load ? sub_addr : ptr_r;
		hit_a = rd_req && addr == `VDS_SUB_DATA_A;
		hit_b = rd_req && addr == `VDS_SUB_DATA_B;
		hit_s = rd_req && addr == `VDS_SUB_STATUS;
		if (sub_load) begin
			ptr_nxt = sub_addr;
		end
		if (rd_req) begin
			ptr_nxt = addr + 8'h01;
			if (hit_a || hit_b || hit_s) begin
				rval_nxt = 1'b1;
				rdat_nxt = hit_a ? a_r : (hit_b ? b_r : status);
			end else begin
				rref_nxt = 1'b1;
			end
		end
		ra_nxt = ra_r || hit_a;
		rb_nxt = rb_r || hit_b;
		// both bytes read clears the flag
		if (valid_r && ra_nxt && rb_nxt) begin
			valid_nxt = 1'b0;
		end
		pcnt_nxt = (pcnt_r != '0) ? pcnt_r - 1'b1 : pcnt_r;
		if (pop) begin
			a_nxt = f_od[15:8];
			b_nxt = f_od[7:0];
			fld_nxt = f_od[16];
			valid_nxt = 1'b1;
			ra_nxt = 1'b0;
			rb_nxt = 1'b0;
			pcnt_nxt = `VDS_PCNT_W'(`VDS_IRQ_PULSE_CYC);
		end
		case (irq_pin_config)
			IRQ_PULSE: begin
				irq_nxt = pcnt_r != '0;
				oen_nxt = 1'b0;
			end
			IRQ_LEVEL: begin
				irq_nxt = valid_r;
				oen_nxt = 1'b0;
			end
			default: begin
				irq_nxt = 1'b0;
				oen_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			a_r <= 8'h00;
			b_r <= 8'h00;
			fld_r <= 1'b0;
			valid_r <= 1'b0;
			ra_r <= 1'b0;
			rb_r <= 1'b0;
			ptr_r <= 8'h00;
			rdat_r <= 8'h00;
			rval_r <= 1'b0;
			rref_r <= 1'b0;
			pcnt_r <= '0;
			irq_r <= 1'b0;
			oen_r <= 1'b1;
		end else begin
			a_r <= a_nxt;
			b_r <= b_nxt;
			fld_r <= fld_nxt;
			valid_r <= valid_nxt;
			ra_r <= ra_nxt;
			rb_r <= rb_nxt;
			ptr_r <= ptr_nxt;
			rdat_r <= rdat_nxt;
			rval_r <= rval_nxt;
			rref_r <= rref_nxt;
			pcnt_r <= pcnt_nxt;
			irq_r <= irq_nxt;
			oen_r <= oen_nxt;
		end
	end

	assign rd_data = rdat_r;
	assign rd_valid = rval_r;
	assign rd_refused = rref_r;
	assign slice_valid_flag = valid_r;
	assign slice_field_flag = sfield;
	assign lost_frame = lost_r;
	assign irq_o = irq_r;
	assign irq_oe_n = oen_r;

	chk_load_valid: assert property (@(posedge clk_sys) disable iff (!nrst)
		pop |=> valid_r && a_r == $past(f_od[15:8]) && b_r == $past(f_od[7:0]))
		else $error("new word not loaded with valid flag");
	chk_clear_valid: assert property (@(posedge clk_sys) disable iff (!nrst)
		valid_r && !pop && ra_r && hit_b |=> !valid_r)
		else $error("valid flag not cleared after both reads");
	chk_field_one: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(valid_r) && ext_class_filter != '0 |-> slice_field_flag)
		else $error("field flag not 1 under class filter");
	chk_irq_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
		irq_pin_config != IRQ_PULSE && irq_pin_config != IRQ_LEVEL
		|=> irq_oe_n)
		else $error("interrupt pin driven while unconfigured");
	chk_irq_pulse: assert property (@(posedge clk_sys) disable iff (!nrst)
		pop ##1 irq_pin_config == IRQ_PULSE [*2] |=> irq_o [*8])
		else $error("no interrupt pulse on new data");
	chk_irq_level: assert property (@(posedge clk_sys) disable iff (!nrst)
		irq_pin_config == IRQ_LEVEL |=> irq_o == $past(valid_r) && !irq_oe_n)
		else $error("level interrupt does not follow valid");
	chk_wss_pass: assert property (@(posedge clk_sys) disable iff (!nrst)
		st_r == RX_HOLD && slice_service && lok &&
		fld == ext_type_filter[0] |-> f_iv)
		else $error("widescreen word filtered");
	chk_raw_pass: assert property (@(posedge clk_sys) disable iff (!nrst)
		st_r == RX_HOLD && !slice_service && ext_class_filter == '0 && lok
		|-> f_iv)
		else $error("unfiltered caption word dropped");
	chk_f2_only: assert property (@(posedge clk_sys) disable iff (!nrst)
		f_iv && xds_on |-> fld)
		else $error("field 1 word passed with class filter");
	chk_refuse: assert property (@(posedge clk_sys) disable iff (!nrst)
		rd_req && !hit_a && !hit_b && !hit_s |=> rd_refused && !rd_valid)
		else $error("control register read not refused");
	chk_incr: assert property (@(posedge clk_sys) disable iff (!nrst)
		rd_req && !sub_load |=> ptr_r == $past(ptr_r) + 8'h01)
		else $error("subaddress not incremented");
endmodule

/* verif/vds_link_model.sv */
// vds_link_model: slicer front end that serialises one sliced-line word.
// assumes the bench calls send only between frames.
module vds_link_model (
	output logic lnk_clk,
	output logic lnk_frame,
	output logic lnk_dat
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		lnk_clk = 1'b0;
		lnk_frame = 1'b0;
		lnk_dat = 1'b0;
	end
	// clock only runs inside a frame, msb first, 125 ns per bit
	task automatic send(input logic [26:0] w, input int nbits);
		lnk_frame = 1'b1;
		for (int i = 26; i > 26 - nbits; i--) begin
			lnk_dat = w[i];
			#62.5;
			lnk_clk = 1'b1;
			#62.5;
			lnk_clk = 1'b0;
		end
		// released line shows junk, never the last bit
		lnk_dat = ~lnk_dat;
		#62.5;
		lnk_frame = 1'b0;
		#62.5;
	endtask
endmodule

/* verif/test_vds_slicer.sv */
// test_vds_slicer: self-checking bench for the slicer readout.
// assumes vds_pkg and the slicer rtl are compiled first.
`define CHK(g, e) \
	begin \
		n_tests++; \
		if ((g) !== (e)) begin \
			fails++; \
			$display("CHECK FAILED at %0t: got %0h want %0h", $time, g, e); \
		end \
	end
module test_vds_slicer;
	timeunit 1ns;
	timeprecision 100ps;
	import vds_pkg::*;
	typedef struct {
		logic srv;
		logic [4:0] cls;
		logic [2:0] typ;
		logic [26:0] w;
		logic hit;
	} vds_row_s;
	logic clk_sys, nrst, lnk_clk, lnk_frame, lnk_dat, slice_service;
	logic [9:0] slice_line_select;
	logic [4:0] ext_class_filter;
	logic [2:0] ext_type_filter;
	vds_irq_e irq_pin_config;
	logic sub_load, rd_req, rd_valid, rd_refused, slice_valid_flag;
	logic [7:0] sub_addr, rd_data;
	logic slice_field_flag, lost_frame, irq_o, irq_oe_n, exp_f;
	logic [7:0] got [0:3];
	logic [7:0] pk [0:5] = '{8'h01, 8'h85, 8'h40, 8'h43, 8'h8f, 8'h68};
	logic [6:0] sum7;
	logic gv [0:3];
	logic gr [0:3];
	vds_row_s rows [0:8];
	int fails = 0;
	int n_tests = 0;
	int n_lost = 0;
	vds_slicer #(.FIFO_D(4)) u_vds_slicer (.clk_sys(clk_sys), .nrst(nrst),
		.lnk_clk(lnk_clk), .lnk_frame(lnk_frame), .lnk_dat(lnk_dat),
		.slice_service(slice_service), .slice_line_select(slice_line_select),
		.ext_class_filter(ext_class_filter),
		.ext_type_filter(ext_type_filter), .irq_pin_config(irq_pin_config),
		.sub_load(sub_load), .sub_addr(sub_addr), .rd_req(rd_req),
		.rd_data(rd_data), .rd_valid(rd_valid), .rd_refused(rd_refused),
		.slice_valid_flag(slice_valid_flag),
		.slice_field_flag(slice_field_flag), .lost_frame(lost_frame),
		.irq_o(irq_o), .irq_oe_n(irq_oe_n));
	vds_link_model u_vds_link_model (.lnk_clk(lnk_clk),
		.lnk_frame(lnk_frame), .lnk_dat(lnk_dat));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// sampled off the launching edge so the pulse is seen settled
	always @(negedge clk_sys) if (lost_frame === 1'b1) n_lost++;
	function automatic logic [26:0] fw(logic f, logic [9:0] l,
		logic [7:0] a, logic [7:0] b);
		return {f, l, a, b};
	endfunction
	task automatic results();
		$display("checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wait_valid();
		int k;
		k = 0;
		while (slice_valid_flag !== 1'b1 && k < 2000) begin
			@(negedge clk_sys);
			k++;
		end
		if (k == 2000) begin
			fails++;
			$display("CHECK FAILED at %0t: no new data", $time);
			results();
		end
	endtask
	// back-to-back reads, first address loaded with the first request
	task automatic burst(input logic [7:0] a, input int n);
		@(negedge clk_sys);
		sub_load = 1'b1;
		sub_addr = a;
		rd_req = 1'b1;
		for (int i = 0; i < n; i++) begin
			@(negedge clk_sys);
			sub_load = 1'b0;
			got[i] = rd_data;
			gv[i] = rd_valid;
			gr[i] = rd_refused;
			if (i == n - 1)
				rd_req = 1'b0;
		end
	endtask
	task automatic frame(input logic [26:0] w);
		u_vds_link_model.send(w, 27);
		wait_valid();
		repeat (3) @(negedge clk_sys);
	endtask
	initial begin
		nrst = 1'b0;
		slice_service = 1'b0;
		slice_line_select = 10'h015;
		ext_class_filter = 5'h00;
		ext_type_filter = 3'h0;
		irq_pin_config = IRQ_OFF;
		sub_load = 1'b0;
		sub_addr = 8'h00;
		rd_req = 1'b0;
		rows[0] = '{1'b0, 5'h00, 3'h0, fw(1'b0, 10'h015, 8'h41, 8'h42), 1'b1};
		rows[1] = '{1'b0, 5'h00, 3'h0, fw(1'b1, 10'h11c, 8'h43, 8'h44), 1'b1};
		rows[2] = '{1'b0, 5'h00, 3'h0, fw(1'b0, 10'h016, 8'h45, 8'h46), 1'b0};
		rows[3] = '{1'b0, 5'h01, 3'h1, fw(1'b1, 10'h11c, 8'h01, 8'h85), 1'b1};
		rows[4] = '{1'b0, 5'h01, 3'h1, fw(1'b0, 10'h015, 8'h01, 8'h85), 1'b0};
		rows[5] = '{1'b0, 5'h02, 3'h0, fw(1'b1, 10'h11c, 8'h01, 8'h85), 1'b0};
		rows[6] = '{1'b1, 5'h00, 3'h0, fw(1'b0, 10'h017, 8'h55, 8'h56), 1'b1};
		rows[7] = '{1'b1, 5'h00, 3'h1, fw(1'b0, 10'h017, 8'h57, 8'h58), 1'b0};
		rows[8] = '{1'b1, 5'h01, 3'h0, fw(1'b0, 10'h017, 8'h59, 8'h5a), 1'b1};
		repeat (16) @(negedge clk_sys);
		`CHK(rd_data, 8'h00);
		`CHK(slice_valid_flag, 1'b0);
		`CHK(irq_oe_n, 1'b1);
		`CHK(slice_field_flag, 1'b0);
		nrst = 1'b1;
		repeat (4) @(negedge clk_sys);
		$display("reset test done");
		for (int i = 0; i < 9; i++) begin
			slice_service = rows[i].srv;
			slice_line_select = rows[i].srv ? 10'h017 : 10'h015;
			ext_class_filter = rows[i].cls;
			ext_type_filter = rows[i].typ;
			u_vds_link_model.send(rows[i].w, 27);
			if (rows[i].hit) begin
				wait_valid();
				exp_f = (rows[i].cls != 5'h00) ? 1'b1 : rows[i].w[26];
				`CHK(slice_field_flag, exp_f);
				burst(8'h2a, 3);
				`CHK(got[0], rows[i].w[15:8]);
				`CHK(got[1], rows[i].w[7:0]);
				// status follows the second byte, so valid is already clear
				`CHK(got[2], {6'h00, 1'b0, exp_f});
			end else
				repeat (40) @(negedge clk_sys);
			@(negedge clk_sys);
			`CHK(slice_valid_flag, 1'b0);
			$display("row %0d done", i);
		end
		slice_service = 1'b0;
		slice_line_select = 10'h015;
		ext_class_filter = 5'h00;
		ext_type_filter = 3'h0;
		// short frame is dropped
		u_vds_link_model.send(fw(1'b0, 10'h015, 8'h71, 8'h72), 26);
		repeat (40) @(negedge clk_sys);
		`CHK(slice_valid_flag, 1'b0);
		// one held, four queued, one waiting, seventh lost
		for (int i = 0; i < 7; i++)
			u_vds_link_model.send(fw(1'b0, 10'h015, 8'h20 + i[7:0],
				8'h60 + i[7:0]), 27);
		`CHK(n_lost, 1);
		for (int i = 0; i < 6; i++) begin
			wait_valid();
			// host fetches both bytes on each new word
			burst(8'h2a, 2);
			`CHK(got[0], 8'h20 + i[7:0]);
			`CHK(got[1], 8'h60 + i[7:0]);
		end
		repeat (2) @(negedge clk_sys);
		`CHK(slice_valid_flag, 1'b0);
		$display("fifo test done");
		// class 01h with type 05h only, one whole rating packet
		ext_class_filter = 5'h01;
		ext_type_filter = 3'h1;
		sum7 = 7'h00;
		for (int i = 0; i < 3; i++) begin
			u_vds_link_model.send(fw(1'b1, 10'h11c, pk[2*i], pk[2*i+1]), 27);
			wait_valid();
			burst(8'h2a, 2);
			`CHK(got[0], pk[2*i]);
			`CHK(got[1], pk[2*i+1]);
			`CHK(^got[0] & ^got[1], 1'b1);
			sum7 = sum7 + got[0][6:0] + got[1][6:0];
		end
		`CHK(sum7, 7'h00);
		ext_class_filter = 5'h00;
		ext_type_filter = 3'h0;
		$display("rating test done");
		irq_pin_config = IRQ_PULSE;
		frame(fw(1'b0, 10'h015, 8'h31, 8'h32));
		`CHK(irq_oe_n, 1'b0);
		`CHK(irq_o, 1'b1);
		repeat (250) @(negedge clk_sys);
		`CHK(irq_o, 1'b0);
		burst(8'h2a, 2);
		irq_pin_config = IRQ_LEVEL;
		frame(fw(1'b0, 10'h015, 8'h33, 8'h34));
		`CHK(irq_o, 1'b1);
		burst(8'h29, 4);
		`CHK(gr[0], 1'b1);
		`CHK(gv[0], 1'b0);
		`CHK(got[1], 8'h33);
		`CHK(got[2], 8'h34);
		repeat (2) @(negedge clk_sys);
		`CHK(irq_o, 1'b0);
		irq_pin_config = IRQ_OFF;
		repeat (3) @(negedge clk_sys);
		`CHK(irq_oe_n, 1'b1);
		$display("irq test done");
		results();
	end
endmodule
